// >>> inc/acllpa_consts.vh
// Constants for the layer-4 access rule match and priority action block.
`ifndef ACLLPA_CONSTS_VH
`define ACLLPA_CONSTS_VH

// Switch register addresses used for indirect access.
`define ACLLPA_REG_IND_CTRL      8'h6E
`define ACLLPA_REG_IND_ADDR      8'h6F
`define ACLLPA_REG_IND_DATA      8'hA0

// Indirect control fields.
`define ACLLPA_TSEL_MSB          7
`define ACLLPA_TSEL_LSB          5
`define ACLLPA_TSEL_RULE         3'h2
`define ACLLPA_PSEL_MSB          3
`define ACLLPA_PSEL_LSB          0
`define ACLLPA_PORT_FIRST        4'h1
`define ACLLPA_PORT_LAST         4'h5

// Rule byte offsets.
`define ACLLPA_OFS_MAX_HI        8'h00
`define ACLLPA_OFS_MAX_LO        8'h01
`define ACLLPA_OFS_MIN_HI        8'h02
`define ACLLPA_OFS_MIN_LO        8'h03
`define ACLLPA_OFS_CMP_PMSB      8'h04
`define ACLLPA_OFS_PROTO_FLAG    8'h05
`define ACLLPA_OFS_FLAG_MASK     8'h06
`define ACLLPA_OFS_FLAG_VALUE    8'h07
`define ACLLPA_OFS_RSVD_EIGHT    8'h08
`define ACLLPA_OFS_RSVD_NINE     8'h09
`define ACLLPA_OFS_PRIO_ACTION   8'h0A

// Field positions inside the rule bytes.
`define ACLLPA_PCM_MSB           2
`define ACLLPA_PCM_LSB           1
`define ACLLPA_PMSB_BIT          0
`define ACLLPA_PLO_MSB           7
`define ACLLPA_PLO_LSB           1
`define ACLLPA_FCE_BIT           0
`define ACLLPA_PMODE_MSB         7
`define ACLLPA_PMODE_LSB         6
`define ACLLPA_RPRIO_MSB         5
`define ACLLPA_RPRIO_LSB         3

// Port comparison and priority override encodings.
`define ACLLPA_PCM_OFF           2'h0
`define ACLLPA_PCM_EITHER        2'h1
`define ACLLPA_PCM_INSIDE        2'h2
`define ACLLPA_PCM_OUTSIDE       2'h3
`define ACLLPA_PRIO_KEEP         2'h0
`define ACLLPA_PRIO_IF_GREATER   2'h1
`define ACLLPA_PRIO_IF_SMALLER   2'h2
`define ACLLPA_PRIO_REPLACE      2'h3

// Reset values.
`define ACLLPA_RST_BYTE          8'h00
`define ACLLPA_RST_WORD          16'h0000

`endif

// >>> rtl/acllpa_cmp.v
// Sixteen-bit port or sequence number comparison against a stored range.
`timescale 1ns/10ps
`default_nettype none
`include "acllpa_consts.vh"

module acllpa_cmp #(
    parameter W = 16
) (
    input  wire [1:0]   mode_i,
    input  wire [W-1:0] value_i,
    input  wire [W-1:0] max_i,
    input  wire [W-1:0] min_i,
    output reg          hit_o
);

    wire in_range;
    wire on_edge;

    // The range is taken as closed, so both bounds count as inside.
    assign in_range = (value_i >= min_i) && (value_i <= max_i);
    assign on_edge  = (value_i == max_i) || (value_i == min_i);

    // A disabled comparison places no condition on the frame.
    always @* begin
        case (mode_i)
            `ACLLPA_PCM_OFF:     hit_o = 1'b1;
            `ACLLPA_PCM_EITHER:  hit_o = on_edge;
            `ACLLPA_PCM_INSIDE:  hit_o = in_range;
            `ACLLPA_PCM_OUTSIDE: hit_o = ~in_range;
            default:             hit_o = 1'b0;
        endcase
    end

endmodule // acllpa_cmp
`default_nettype wire

// >>> rtl/acllpa_top.v
// Per-port layer-4 access rule storage, matching and priority override.
`timescale 1ns/10ps
`default_nettype none
`include "acllpa_consts.vh"

// Function
// - Offset register picks the byte; data window reads and writes it.
// - Port compare mode: off, equal either bound, inside, outside range.
// - Eight-bit protocol value split between two bytes is matched.
// - Flag compare enable bit decides whether TCP flags join the match.
// - Bytes eight and nine are reserved, reset to zero, nine read-only.
// - Mode 00 keeps class priority; 01 uses rule priority when greater.
// - Mode 10 uses rule priority when smaller; 11 replaces it on any tagged frame that hits the rule.
// - Action byte holds mode in bits 7:6, priority in 5:3, zero at reset.
// - Sixteen-bit maximum and minimum values are stored and compared.
module acllpa_top #(
    parameter NPORT = 5,
    parameter PW    = 16
) (
    input  wire          clock_i,
    input  wire          resetn_i,
    // Switch register access port.
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    input  wire [7:0]    reg_addr_i,
    input  wire [7:0]    reg_wdata_i,
    output reg  [7:0]    reg_rdata_o,
    output reg           reg_rvalid_o,
    // Parsed frame header fields.
    input  wire          frm_valid_i,
    input  wire [3:0]    frm_port_i,
    input  wire [PW-1:0] frm_l4_value_i,
    input  wire [7:0]    frm_ip_proto_i,
    input  wire [7:0]    frm_tcp_flags_i,
    input  wire          frm_tagged_i,
    input  wire [2:0]    frm_class_prio_i,
    // Rule result.
    output reg           res_valid_o,
    output reg           res_match_o,
    output reg  [2:0]    res_prio_o,
    output reg           res_prio_changed_o
);

    integer i;

    // Indirect access registers.
    reg  [7:0]    ind_ctrl_ff;
    reg  [7:0]    ind_addr_ff;

    // Rule storage, one entry per port.
    reg  [PW-1:0] max_val_ff    [0:NPORT-1];
    reg  [PW-1:0] min_val_ff    [0:NPORT-1];
    reg  [2:0]    cmp_pmsb_ff   [0:NPORT-1];
    reg  [7:0]    proto_flag_ff [0:NPORT-1];
    reg  [7:0]    flag_mask_ff  [0:NPORT-1];
    reg  [7:0]    flag_value_ff [0:NPORT-1];
    reg  [7:0]    rsvd_eight_ff [0:NPORT-1];
    reg  [4:0]    prio_act_ff   [0:NPORT-1];

    // Returns high when a four-bit port number names a real port.
    function port_ok;
        input [3:0] pnum;
        begin
            port_ok = (pnum >= `ACLLPA_PORT_FIRST) && (pnum <= `ACLLPA_PORT_LAST);
        end
    endfunction

    // Converts a one-based port number to a storage index.
    // A number outside the port range lands past the storage or on another port's entry, so callers gate on port_ok.
    function [2:0] port_idx;
        input [3:0] pnum;
        reg   [3:0] tmp;
        begin
            tmp      = pnum - `ACLLPA_PORT_FIRST;
            port_idx = tmp[2:0];
        end
    endfunction

    wire       tbl_sel;
    wire       acc_ok;
    wire [2:0] acc_idx;
    wire       win_wr;

    // The window only opens onto the rule table of a valid port.
    assign tbl_sel = ind_ctrl_ff[`ACLLPA_TSEL_MSB:`ACLLPA_TSEL_LSB] == `ACLLPA_TSEL_RULE;
    assign acc_ok  = tbl_sel && port_ok(ind_ctrl_ff[`ACLLPA_PSEL_MSB:`ACLLPA_PSEL_LSB]);
    assign acc_idx = port_idx(ind_ctrl_ff[`ACLLPA_PSEL_MSB:`ACLLPA_PSEL_LSB]);
    assign win_wr  = reg_wr_i && (reg_addr_i == `ACLLPA_REG_IND_DATA) && acc_ok;

    // Indirect control and offset registers.
    // All eight control bits are kept and read back, the unused bit 4 included.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            ind_ctrl_ff <= `ACLLPA_RST_BYTE;
            ind_addr_ff <= `ACLLPA_RST_BYTE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ACLLPA_REG_IND_CTRL) begin
                ind_ctrl_ff <= reg_wdata_i;
            end
            if (reg_addr_i == `ACLLPA_REG_IND_ADDR) begin
                ind_addr_ff <= reg_wdata_i;
            end
        end
    end

    // Rule byte writes through the data window.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            for (i = 0; i < NPORT; i = i + 1) begin
                max_val_ff[i]    <= `ACLLPA_RST_WORD;
                min_val_ff[i]    <= `ACLLPA_RST_WORD;
                cmp_pmsb_ff[i]   <= 3'h0;
                proto_flag_ff[i] <= `ACLLPA_RST_BYTE;
                flag_mask_ff[i]  <= `ACLLPA_RST_BYTE;
                flag_value_ff[i] <= `ACLLPA_RST_BYTE;
                rsvd_eight_ff[i] <= `ACLLPA_RST_BYTE;
                prio_act_ff[i]   <= 5'h00;
            end
        end else if (win_wr) begin
            case (ind_addr_ff)
                `ACLLPA_OFS_MAX_HI: begin
                    max_val_ff[acc_idx][15:8] <= reg_wdata_i;
                end
                `ACLLPA_OFS_MAX_LO: begin
                    max_val_ff[acc_idx][7:0] <= reg_wdata_i;
                end
                `ACLLPA_OFS_MIN_HI: begin
                    min_val_ff[acc_idx][15:8] <= reg_wdata_i;
                end
                `ACLLPA_OFS_MIN_LO: begin
                    min_val_ff[acc_idx][7:0] <= reg_wdata_i;
                end
                `ACLLPA_OFS_CMP_PMSB: begin
                    cmp_pmsb_ff[acc_idx] <= reg_wdata_i[2:0];
                end
                `ACLLPA_OFS_PROTO_FLAG: begin
                    proto_flag_ff[acc_idx] <= reg_wdata_i;
                end
                `ACLLPA_OFS_FLAG_MASK: begin
                    flag_mask_ff[acc_idx] <= reg_wdata_i;
                end
                `ACLLPA_OFS_FLAG_VALUE: begin
                    flag_value_ff[acc_idx] <= reg_wdata_i;
                end
                `ACLLPA_OFS_RSVD_EIGHT: begin
                    rsvd_eight_ff[acc_idx] <= reg_wdata_i;
                end
                `ACLLPA_OFS_PRIO_ACTION: begin
                    prio_act_ff[acc_idx] <= reg_wdata_i[7:3];
                end
                default: begin
                    // Byte nine is read-only and other offsets hold nothing here.
                end
            endcase
        end
    end

    reg [7:0] win_byte;

    // Byte presented through the data window for the current offset.
    always @* begin
        win_byte = 8'h00;
        if (acc_ok) begin
            case (ind_addr_ff)
                `ACLLPA_OFS_MAX_HI:      win_byte = max_val_ff[acc_idx][15:8];
                `ACLLPA_OFS_MAX_LO:      win_byte = max_val_ff[acc_idx][7:0];
                `ACLLPA_OFS_MIN_HI:      win_byte = min_val_ff[acc_idx][15:8];
                `ACLLPA_OFS_MIN_LO:      win_byte = min_val_ff[acc_idx][7:0];
                `ACLLPA_OFS_CMP_PMSB:    win_byte = {5'h00, cmp_pmsb_ff[acc_idx]};
                `ACLLPA_OFS_PROTO_FLAG:  win_byte = proto_flag_ff[acc_idx];
                `ACLLPA_OFS_FLAG_MASK:   win_byte = flag_mask_ff[acc_idx];
                `ACLLPA_OFS_FLAG_VALUE:  win_byte = flag_value_ff[acc_idx];
                `ACLLPA_OFS_RSVD_EIGHT:  win_byte = rsvd_eight_ff[acc_idx];
                `ACLLPA_OFS_RSVD_NINE:   win_byte = 8'h00;
                `ACLLPA_OFS_PRIO_ACTION: win_byte = {prio_act_ff[acc_idx], 3'h0};
                default:                 win_byte = 8'h00;
            endcase
        end
    end

    // Register read data; unknown addresses answer zero.
    // Reading the window has no side effect, so software may poll a byte freely.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o  <= `ACLLPA_RST_BYTE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ACLLPA_REG_IND_CTRL: reg_rdata_o <= ind_ctrl_ff;
                    `ACLLPA_REG_IND_ADDR: reg_rdata_o <= ind_addr_ff;
                    `ACLLPA_REG_IND_DATA: reg_rdata_o <= win_byte;
                    default:              reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Frame side: pick the entry of the ingress port.
    wire          frm_ok;
    wire [2:0]    frm_idx;
    wire [1:0]    port_compare_mode;
    wire [7:0]    rule_proto;
    wire          flag_compare_enable;
    wire [7:0]    fmask;
    wire [7:0]    fvalue;
    wire [1:0]    priority_override_mode;
    wire [2:0]    rule_prio;
    wire          range_hit;
    wire          proto_hit;
    wire          flag_hit;
    wire          rule_hit;

    // A bad port falls back to entry zero so no read runs past the storage; frm_ok still blocks the hit.
    assign frm_ok     = port_ok(frm_port_i);
    assign frm_idx    = frm_ok ? port_idx(frm_port_i) : 3'h0;
    assign port_compare_mode = cmp_pmsb_ff[frm_idx][`ACLLPA_PCM_MSB:`ACLLPA_PCM_LSB];
    assign rule_proto = {cmp_pmsb_ff[frm_idx][`ACLLPA_PMSB_BIT],
                         proto_flag_ff[frm_idx][`ACLLPA_PLO_MSB:`ACLLPA_PLO_LSB]};
    assign flag_compare_enable = proto_flag_ff[frm_idx][`ACLLPA_FCE_BIT];
    assign fmask      = flag_mask_ff[frm_idx];
    assign fvalue     = flag_value_ff[frm_idx];
    assign priority_override_mode = prio_act_ff[frm_idx][`ACLLPA_PMODE_MSB-3:`ACLLPA_PMODE_LSB-3];
    assign rule_prio  = prio_act_ff[frm_idx][`ACLLPA_RPRIO_MSB-3:`ACLLPA_RPRIO_LSB-3];

    // Range check on the selected entry.
    // One comparator serves the ingress entry; the rules of other ports stay idle.
    acllpa_cmp #(
        .W       (PW)
    ) u_cmp (
        .mode_i  (port_compare_mode),
        .value_i (frm_l4_value_i),
        .max_i   (max_val_ff[frm_idx]),
        .min_i   (min_val_ff[frm_idx]),
        .hit_o   (range_hit)
    );

    // Masking both sides keeps unmasked stored bits from blocking a hit.
    // The protocol is always compared; there is no enable for it.
    assign proto_hit = frm_ip_proto_i == rule_proto;
    assign flag_hit  = ~flag_compare_enable || ((frm_tcp_flags_i & fmask) == (fvalue & fmask));
    assign rule_hit  = frm_ok && range_hit && proto_hit && flag_hit;

    reg [2:0] nxt_prio;
    reg       nxt_changed;

    // Priority override; untagged frames and misses keep the class result.
    // Only a tagged frame carries a priority field that the rule may override.
    always @* begin
        nxt_prio    = frm_class_prio_i;
        nxt_changed = 1'b0;
        if (rule_hit && frm_tagged_i) begin
            case (priority_override_mode)
                `ACLLPA_PRIO_KEEP: begin
                    nxt_prio = frm_class_prio_i;
                end
                `ACLLPA_PRIO_IF_GREATER: begin
                    if (rule_prio > frm_class_prio_i) begin
                        nxt_prio    = rule_prio;
                        nxt_changed = 1'b1;
                    end
                end
                `ACLLPA_PRIO_IF_SMALLER: begin
                    if (rule_prio < frm_class_prio_i) begin
                        nxt_prio    = rule_prio;
                        nxt_changed = 1'b1;
                    end
                end
                `ACLLPA_PRIO_REPLACE: begin
                    nxt_prio    = rule_prio;
                    nxt_changed = 1'b1;
                end
                default: begin
                    nxt_prio = frm_class_prio_i;
                end
            endcase
        end
    end

    // Result registers, one cycle after the frame fields.
    // Match and priority hold between frames; only the valid pulse drops.
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            res_valid_o        <= 1'b0;
            res_match_o        <= 1'b0;
            res_prio_o         <= 3'h0;
            res_prio_changed_o <= 1'b0;
        end else begin
            res_valid_o <= frm_valid_i;
            if (frm_valid_i) begin
                res_match_o        <= rule_hit;
                res_prio_o         <= nxt_prio;
                res_prio_changed_o <= nxt_changed;
            end
        end
    end

endmodule // acllpa_top
`default_nettype wire

// >>> sim/acllpa_checker.sv
// Concurrent checks on the rule block's register and frame ports.
`timescale 1ns/10ps
`default_nettype none
module acllpa_checker (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       reg_rd_i,
    input wire logic       reg_rvalid_o,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       frm_valid_i,
    input wire logic [3:0] frm_port_i,
    input wire logic       frm_tagged_i,
    input wire logic [2:0] frm_class_prio_i,
    input wire logic       res_valid_o,
    input wire logic       res_match_o,
    input wire logic [2:0] res_prio_o,
    input wire logic       res_prio_changed_o
);
    // One clock domain, so clock and reset are named once for all checks.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // Answers come exactly one edge after the request, and never unasked.
    a_read_answer_timing: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read answer missing");
    a_read_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read answer without read");
    // The reset edge clears the data, so the edge after it is skipped.
    a_read_data_holds: assert property (!reg_rvalid_o && $past(resetn_i) |-> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_frame_answer_timing: assert property (frm_valid_i |=> res_valid_o)
        else $error("frame result missing");
    a_frame_answer_cause: assert property (res_valid_o |-> $past(frm_valid_i))
        else $error("frame result without frame");
    a_bad_port_passes: assert property (frm_valid_i && (frm_port_i == 4'h0 || frm_port_i > 4'h5) |=>
        !res_match_o && !res_prio_changed_o && res_prio_o == $past(frm_class_prio_i))
        else $error("bad port frame matched");
    a_untagged_keeps_prio: assert property (frm_valid_i && !frm_tagged_i |=>
        !res_prio_changed_o && res_prio_o == $past(frm_class_prio_i))
        else $error("untagged frame priority changed");
    a_miss_keeps_prio: assert property (res_valid_o && !res_match_o |->
        !res_prio_changed_o && res_prio_o == $past(frm_class_prio_i))
        else $error("missed rule changed priority");
    a_change_needs_match: assert property (res_prio_changed_o |-> res_match_o)
        else $error("priority changed without hit");
endmodule // acllpa_checker

bind acllpa_top acllpa_checker u_checker (.clock_i(clock_i), .resetn_i(resetn_i), .reg_rd_i(reg_rd_i),
    .reg_rvalid_o(reg_rvalid_o), .reg_rdata_o(reg_rdata_o), .frm_valid_i(frm_valid_i),
    .frm_port_i(frm_port_i), .frm_tagged_i(frm_tagged_i), .frm_class_prio_i(frm_class_prio_i),
    .res_valid_o(res_valid_o), .res_match_o(res_match_o), .res_prio_o(res_prio_o),
    .res_prio_changed_o(res_prio_changed_o));
`default_nettype wire

// >>> sim/acl_l4_match_priority_action_bench.sv
// Self-checking bench for the layer-4 rule match and priority action block.
`timescale 1ns/10ps
`default_nettype none
module acl_l4_match_priority_action_bench;
    typedef struct packed {
        logic [1:0]  pcm;
        logic [1:0]  pom;
        logic [2:0]  rp;
        logic [15:0] l4;
        logic [7:0]  fl;
        logic        tag;
        logic        m;
        logic [2:0]  p;
        logic        ch;
    } acllpa_row_t;

    logic        clock_i, resetn_i, reg_wr_i, reg_rd_i, frm_valid_i, frm_tagged_i;
    logic [7:0]  reg_addr_i, reg_wdata_i, frm_ip_proto_i, frm_tcp_flags_i, reg_rdata_o;
    logic [3:0]  frm_port_i;
    logic [15:0] frm_l4_value_i;
    logic [2:0]  frm_class_prio_i, res_prio_o;
    logic        reg_rvalid_o, res_valid_o, res_match_o, res_prio_changed_o;
    int          errors, checked, i;
    // Rule range is 0x0050 to 0x0100; class priority is always 3.
    acllpa_row_t rows [14] = '{
        '{2'h0, 2'h0, 3'h5, 16'h0000, 8'h02, 1'b1, 1'b1, 3'h3, 1'b0},
        '{2'h1, 2'h3, 3'h5, 16'h0100, 8'h02, 1'b1, 1'b1, 3'h5, 1'b1},
        '{2'h1, 2'h3, 3'h5, 16'h0050, 8'h02, 1'b1, 1'b1, 3'h5, 1'b1},
        '{2'h1, 2'h3, 3'h5, 16'h0080, 8'h02, 1'b1, 1'b0, 3'h3, 1'b0},
        '{2'h2, 2'h1, 3'h5, 16'h0050, 8'h02, 1'b1, 1'b1, 3'h5, 1'b1},
        '{2'h2, 2'h1, 3'h2, 16'h0100, 8'h02, 1'b1, 1'b1, 3'h3, 1'b0},
        '{2'h2, 2'h2, 3'h2, 16'h0101, 8'h02, 1'b1, 1'b0, 3'h3, 1'b0},
        '{2'h2, 2'h2, 3'h2, 16'h00FF, 8'h02, 1'b1, 1'b1, 3'h2, 1'b1},
        '{2'h3, 2'h2, 3'h5, 16'h004F, 8'h02, 1'b1, 1'b1, 3'h3, 1'b0},
        '{2'h3, 2'h3, 3'h6, 16'h0080, 8'h02, 1'b1, 1'b0, 3'h3, 1'b0},
        '{2'h3, 2'h3, 3'h6, 16'h0200, 8'h02, 1'b0, 1'b1, 3'h3, 1'b0},
        '{2'h0, 2'h1, 3'h3, 16'h0000, 8'h02, 1'b1, 1'b1, 3'h3, 1'b0},
        '{2'h0, 2'h3, 3'h6, 16'h0000, 8'h03, 1'b1, 1'b1, 3'h6, 1'b1},
        '{2'h0, 2'h3, 3'h6, 16'h0000, 8'h12, 1'b1, 1'b0, 3'h3, 1'b0}};

    acllpa_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .frm_valid_i(frm_valid_i), .frm_port_i(frm_port_i),
        .frm_l4_value_i(frm_l4_value_i), .frm_ip_proto_i(frm_ip_proto_i), .frm_tcp_flags_i(frm_tcp_flags_i),
        .frm_tagged_i(frm_tagged_i), .frm_class_prio_i(frm_class_prio_i), .res_valid_o(res_valid_o),
        .res_match_o(res_match_o), .res_prio_o(res_prio_o), .res_prio_changed_o(res_prio_changed_o));

    // Compares one register byte; an unknown never counts as a match.
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobes last one cycle, so each access ends by dropping them at the next falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    // The answer stands one cycle after the read edge; valid is sampled then, the held data a cycle later.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        cmp("read valid", 8'h01, {7'h00, reg_rvalid_o});
        @(negedge clock_i);
        cmp("read data", exp, reg_rdata_o);
        cmp("read valid end", 8'h00, {7'h00, reg_rvalid_o});
    endtask

    // Selects the rule table for a port, then the byte offset.
    task automatic sel(input logic [3:0] port, input logic [7:0] ofs);
        wr(8'h6E, {3'h2, 1'b0, port});
        wr(8'h6F, ofs);
    endtask

    task automatic wb(input logic [3:0] port, input logic [7:0] ofs, input logic [7:0] d);
        sel(port, ofs);
        wr(8'hA0, d);
    endtask

    task automatic rb(input logic [3:0] port, input logic [7:0] ofs, input logic [7:0] exp);
        sel(port, ofs);
        rd(8'hA0, exp);
    endtask

    // Sends one frame with class priority 3 and compares the result one cycle later.
    task automatic frame(input logic [3:0] port, input logic [15:0] l4, input logic [7:0] pr, input logic [7:0] fl,
                         input logic tag, input logic m, input logic [2:0] p, input logic ch);
        @(negedge clock_i);
        frm_valid_i = 1'b1;
        frm_port_i = port;
        frm_l4_value_i = l4;
        frm_ip_proto_i = pr;
        frm_tcp_flags_i = fl;
        frm_tagged_i = tag;
        frm_class_prio_i = 3'h3;
        @(negedge clock_i);
        frm_valid_i = 1'b0;
        checked++;
        if ({res_valid_o, res_match_o, res_prio_o, res_prio_changed_o} !== {1'b1, m, p, ch}) begin
            errors++;
            $display("wrong value frame result expected %h seen %h", {1'b1, m, p, ch},
                     {res_valid_o, res_match_o, res_prio_o, res_prio_changed_o});
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Free-running 40 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Cuts a hang short; the whole run needs well under this many cycles.
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        report_and_stop();
    end

    // Main sequence: reset values, table rows, then the awkward cases.
    initial begin
        {resetn_i, reg_wr_i, reg_rd_i, frm_valid_i, frm_tagged_i} = 5'h00;
        {reg_addr_i, reg_wdata_i, frm_ip_proto_i, frm_tcp_flags_i} = 32'h00000000;
        {frm_port_i, frm_l4_value_i, frm_class_prio_i} = 23'h000000;
        errors = 0;
        checked = 0;
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        rd(8'h6E, 8'h00);
        for (i = 5; i <= 9; i++) rb(4'h1, i[7:0], 8'h00);
        rb(4'h1, 8'h0A, 8'h00);
        $display("test reset values done");
        // Port 1 rule: protocol 0x06, flag compare on, mask 0x12, value 0x02.
        wb(4'h1, 8'h00, 8'h01);
        wb(4'h1, 8'h01, 8'h00);
        wb(4'h1, 8'h02, 8'h00);
        wb(4'h1, 8'h03, 8'h50);
        wb(4'h1, 8'h05, 8'h0D);
        wb(4'h1, 8'h06, 8'h12);
        wb(4'h1, 8'h07, 8'h02);
        rb(4'h1, 8'h06, 8'h12);
        rb(4'h1, 8'h00, 8'h01);
        for (i = 0; i < 14; i++) begin
            wb(4'h1, 8'h04, {5'h00, rows[i].pcm, 1'b0});
            wb(4'h1, 8'h0A, {rows[i].pom, rows[i].rp, 3'h0});
            frame(4'h1, rows[i].l4, 8'h06, rows[i].fl, rows[i].tag, rows[i].m, rows[i].p, rows[i].ch);
        end
        $display("test table rows done");
        // Top protocol bit lives in the byte before the low seven bits.
        frame(4'h1, 16'h0000, 8'h86, 8'h02, 1'b1, 1'b0, 3'h3, 1'b0);
        wb(4'h1, 8'h04, 8'h01);
        frame(4'h1, 16'h0000, 8'h86, 8'h02, 1'b1, 1'b1, 3'h6, 1'b1);
        frame(4'h1, 16'h0000, 8'h86, 8'hEB, 1'b1, 1'b1, 3'h6, 1'b1);
        wb(4'h1, 8'h05, 8'h0C);
        frame(4'h1, 16'h0000, 8'h86, 8'h12, 1'b1, 1'b1, 3'h6, 1'b1);
        frame(4'h6, 16'h0000, 8'h86, 8'h12, 1'b1, 1'b0, 3'h3, 1'b0);
        $display("test protocol and flags done");
        wb(4'h1, 8'h09, 8'hFF);
        rb(4'h1, 8'h09, 8'h00);
        wb(4'h1, 8'h08, 8'hA5);
        rb(4'h1, 8'h08, 8'hA5);
        wb(4'h1, 8'h0A, 8'hFF);
        rb(4'h1, 8'h0A, 8'hF8);
        rb(4'h2, 8'h06, 8'h00);
        rd(8'h6E, 8'h42);
        // A wrong table select must neither write nor read the rule bytes.
        wr(8'h6E, 8'h21);
        wr(8'h6F, 8'h06);
        wr(8'hA0, 8'h77);
        rd(8'hA0, 8'h00);
        rb(4'h1, 8'h06, 8'h12);
        $display("test register access done");
        @(negedge clock_i);
        resetn_i = 1'b0;
        @(negedge clock_i);
        resetn_i = 1'b1;
        rb(4'h1, 8'h06, 8'h00);
        rb(4'h1, 8'h0A, 8'h00);
        $display("test second reset done");
        report_and_stop();
    end
endmodule // acl_l4_match_priority_action_bench
`default_nettype wire
